// file: dpc_top.sv
// Purpose: Datapath control register of a video link deserializer
// Assumes: Forward-channel loads arrive as one-cycle strobes in sys_clk domain
// Notes:   Decoded controls leave flops one cycle after the register changes
`timescale 1ns/10ps

// Notes on behaviour
// - Lock bit set ignores forward-channel loads
// - Lock clear lets forward channel load bits 6..0
// - Pixel pass forwards data ignoring framing
// - Pixel pass disables protection, blocks packet audio
// - Pixel pass void without remote protection support
// - Sense bit: 1 active low, 0 active high
// - Regen bit 1 keeps packet audio off pins
// - Override 0 forces four-channel audio off
// - Depth bit 1 selects 18-bit, else 24-bit
// - Transport bit 1 in-band, else data island
// - Enable bit turns four-channel audio on
module dpc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [ADDR_W-1:0]              s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic                           fc_load_valid,
  input  wire logic [dpc_pkg::DPC_FC_W-1:0]   fc_load_data,
  input  wire logic                           remote_cp_capable,
  input  wire logic                           video_valid_flag,
  output logic                                lock_local_settings,
  output logic                                frameless_pixel_pass,
  output logic                                video_valid_sense,
  output logic                                audio_relay_regen,
  output logic                                pixel_gate,
  output logic                                cp_disable,
  output logic                                packet_audio_block,
  output logic                                four_channel_en,
  output logic                                color_18bit_mode,
  output logic                                inband_transport
);
  localparam int DW = dpc_pkg::DPC_DATA_W;
  localparam int FW = dpc_pkg::DPC_FC_W;

  dpc_reg_if regs_if ();

  logic [DW-1:0] ctrl_reg;
  logic [DW-1:0] ctrl_next;

  // Bus slave; it owns the handshake and address decode
  dpc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .sys_clk (sys_clk),
    .reset   (reset),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .regs    (regs_if)
  );

  // Field views of the stored word
  wire lock_bit   = ctrl_reg[dpc_pkg::DPC_BIT_LOCK];
  wire pass_bit   = ctrl_reg[dpc_pkg::DPC_BIT_PASS];
  wire sense_bit  = ctrl_reg[dpc_pkg::DPC_BIT_SENSE];
  wire regen_bit  = ctrl_reg[dpc_pkg::DPC_BIT_REGEN];
  wire ovr4_bit   = ctrl_reg[dpc_pkg::DPC_BIT_4CH_OVR];
  wire depth_bit  = ctrl_reg[dpc_pkg::DPC_BIT_DEPTH18];
  wire inband_bit = ctrl_reg[dpc_pkg::DPC_BIT_INBAND];
  wire en4_bit    = ctrl_reg[dpc_pkg::DPC_BIT_4CH_EN];

  // Update sources; a local write beats a forward load in the same cycle,
  // since software is the later authority and the remote can resend
  wire local_we = regs_if.wr_en;
  wire fc_we    = fc_load_valid & ~lock_bit;

  // Next value of the control word
  always_comb begin
    ctrl_next = ctrl_reg;
    if (local_we) begin
      ctrl_next = regs_if.wr_data;
    end else if (fc_we) begin
      ctrl_next = {lock_bit, fc_load_data};
    end
  end

  assign regs_if.rd_data = ctrl_reg;

  // Stored control word, zero after reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= dpc_pkg::DPC_RESET_VALUE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Decoded controls; pass needs a remote that supports protection
  wire pass_eff     = pass_bit & remote_cp_capable;
  wire frame_active = sense_bit ? ~video_valid_flag : video_valid_flag;
  wire gate_next    = pass_eff | frame_active;
  wire audio_next   = pass_eff | regen_bit;
  wire four_next    = ovr4_bit & en4_bit;

  // Registered outputs; costs one cycle of latency but keeps them glitch free
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lock_local_settings  <= 1'b0;
      frameless_pixel_pass <= 1'b0;
      video_valid_sense    <= 1'b0;
      audio_relay_regen    <= 1'b0;
      pixel_gate           <= 1'b0;
      cp_disable           <= 1'b0;
      packet_audio_block   <= 1'b0;
      four_channel_en      <= 1'b0;
      color_18bit_mode     <= 1'b0;
      inband_transport     <= 1'b0;
    end else begin
      lock_local_settings  <= lock_bit;
      frameless_pixel_pass <= pass_eff;
      video_valid_sense    <= sense_bit;
      audio_relay_regen    <= regen_bit;
      pixel_gate           <= gate_next;
      cp_disable           <= pass_eff;
      packet_audio_block   <= audio_next;
      four_channel_en      <= four_next;
      color_18bit_mode     <= depth_bit;
      inband_transport     <= inband_bit;
    end
  end

  // Checks on the register bank and its decoded controls
  default clocking dpc_cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Locked word ignores a forward load that has no local write beside it, checked in the next cycle
  sequence s_locked_fc;
    lock_bit && fc_load_valid && !local_we;
  endsequence

  a_lock_blocks_fc: assert property (
    s_locked_fc |=> $stable(ctrl_reg[FW-1:0]))
    else $error("forward load changed a locked register");

  a_lock_bit_kept: assert property (
    fc_load_valid && !local_we |=> ctrl_reg[dpc_pkg::DPC_BIT_LOCK] == $past(lock_bit))
    else $error("forward load altered the lock bit");

  a_fc_load_applies: assert property (
    !lock_bit && fc_load_valid && !local_we |=> ctrl_reg[FW-1:0] == $past(fc_load_data))
    else $error("forward load not applied while unlocked");

  a_local_write: assert property (
    local_we |=> ctrl_reg == $past(regs_if.wr_data))
    else $error("local write not stored");

  a_reset_zero: assert property (
    $fell(reset) |-> ctrl_reg == dpc_pkg::DPC_RESET_VALUE)
    else $error("register not zero after reset");

  a_hold_idle: assert property (
    !local_we && !fc_load_valid |=> $stable(ctrl_reg))
    else $error("register changed without a source");

  a_pass_ignores_frame: assert property (
    pass_bit && remote_cp_capable |=> pixel_gate && frameless_pixel_pass)
    else $error("pixel pass did not open the gate");

  a_pass_side_effects: assert property (
    pass_bit && remote_cp_capable |=> cp_disable && packet_audio_block)
    else $error("pixel pass left protection or audio on");

  a_pass_needs_remote: assert property (
    !remote_cp_capable |=> !cp_disable && !frameless_pixel_pass)
    else $error("pixel pass acted without remote support");

  a_sense_low: assert property (
    !pass_eff && sense_bit |=> pixel_gate == !$past(video_valid_flag))
    else $error("active low framing misread");

  a_sense_high: assert property (
    !pass_eff && !sense_bit |=> pixel_gate == $past(video_valid_flag))
    else $error("active high framing misread");

  a_regen_blocks: assert property (
    regen_bit |=> packet_audio_block)
    else $error("regen set but packet audio passed");

  a_audio_default: assert property (
    !regen_bit && !pass_eff |=> !packet_audio_block)
    else $error("packet audio blocked by default");

  a_four_ch_forced: assert property (
    !ovr4_bit |=> !four_channel_en)
    else $error("four channel on without override");

  a_four_ch_follow: assert property (
    ovr4_bit |=> four_channel_en == $past(en4_bit))
    else $error("four channel does not follow enable");

  a_depth_select: assert property (
    ##1 color_18bit_mode == $past(depth_bit))
    else $error("colour depth output wrong");

  a_transport_sel: assert property (
    ##1 inband_transport == $past(inband_bit))
    else $error("audio transport output wrong");

  // Main scenarios to be reached
  c_fc_load: cover property (!lock_bit && fc_load_valid ##1 ctrl_reg[FW-1:0] != 7'h00);
  c_fc_blocked: cover property (s_locked_fc);
  c_local_lock: cover property (local_we ##1 lock_bit);
  c_pass_active: cover property (pass_eff ##1 cp_disable);
endmodule : dpc_top

// file: dpc_pkg.sv
// Purpose: Shared constants for the datapath control register bank
// Assumes: 8-bit register behind a 32-bit AXI4-Lite slave
// Notes:   Register index is kept as printed; byte address is four times it
package dpc_pkg;
  // Register geometry
  localparam int          DPC_DATA_W        = 8;
  localparam int          DPC_FC_W          = 7;
  localparam logic [7:0]  DPC_REG_INDEX     = 8'h22;
  localparam int          DPC_WORD_SHIFT    = 2;
  localparam logic [7:0]  DPC_RESET_VALUE   = 8'h00;

  // Field positions
  localparam int          DPC_BIT_LOCK      = 7;
  localparam int          DPC_BIT_PASS      = 6;
  localparam int          DPC_BIT_SENSE     = 5;
  localparam int          DPC_BIT_REGEN     = 4;
  localparam int          DPC_BIT_4CH_OVR   = 3;
  localparam int          DPC_BIT_DEPTH18   = 2;
  localparam int          DPC_BIT_INBAND    = 1;
  localparam int          DPC_BIT_4CH_EN    = 0;

  // AXI4-Lite answers
  localparam logic [1:0]  DPC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  DPC_RESP_SLVERR   = 2'h2;
  localparam logic [31:0] DPC_RDATA_ZERO    = 32'h0000_0000;
endpackage : dpc_pkg

// file: dpc_reg_if.sv
// Purpose: Carrier between the bus slave and the register bank
// Assumes: One local write per cycle at most
// Notes:   The slave does address decode; the bank only sees a hit
`timescale 1ns/10ps
interface dpc_reg_if;
  logic                               wr_en;
  logic [dpc_pkg::DPC_DATA_W-1:0]     wr_data;
  logic [dpc_pkg::DPC_DATA_W-1:0]     rd_data;

  modport slave (output wr_en, output wr_data, input rd_data);
  modport bank  (input wr_en, input wr_data, output rd_data);
endinterface : dpc_reg_if

// file: dpc_axil_slave.sv
// Purpose: AXI4-Lite slave for the single datapath control word
// Assumes: One write and one read outstanding at most
// Notes:   Unmapped addresses answer SLVERR and read as zero
`timescale 1ns/10ps
module dpc_axil_slave #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  dpc_reg_if.slave               regs
);
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0]        w_data_reg;
  logic              w_strb0_reg;

  // Handshake terms; address and data may arrive in either order
  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire ar_take  = arvalid & arready;
  wire do_write = aw_held_reg & w_held_reg & ~bvalid;
  wire wr_hit   = aw_addr_reg[ADDR_W-1:dpc_pkg::DPC_WORD_SHIFT] ==
                  (ADDR_W-dpc_pkg::DPC_WORD_SHIFT)'(dpc_pkg::DPC_REG_INDEX);
  wire rd_hit   = araddr[ADDR_W-1:dpc_pkg::DPC_WORD_SHIFT] ==
                  (ADDR_W-dpc_pkg::DPC_WORD_SHIFT)'(dpc_pkg::DPC_REG_INDEX);

  wire aw_held_next = (aw_held_reg | aw_take) & ~do_write;
  wire w_held_next  = (w_held_reg | w_take) & ~do_write;
  wire bvalid_next  = do_write | (bvalid & ~bready);
  wire rvalid_next  = ar_take | (rvalid & ~rready);

  // Only byte lane 0 carries the register; other lanes are dropped
  assign regs.wr_en   = do_write & wr_hit & w_strb0_reg;
  assign regs.wr_data = w_data_reg;

  // Write path state; readies are precomputed so they leave a flop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= dpc_pkg::DPC_RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awready     <= ~aw_held_next & ~bvalid_next;
      wready      <= ~w_held_next & ~bvalid_next;
      bvalid      <= bvalid_next;
      if (do_write) begin
        bresp <= wr_hit ? dpc_pkg::DPC_RESP_OKAY : dpc_pkg::DPC_RESP_SLVERR;
      end
    end
  end

  // Payload capture at acceptance
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb0_reg <= 1'b0;
    end else begin
      if (aw_take) aw_addr_reg <= awaddr;
      if (w_take) begin
        w_data_reg  <= wdata[7:0];
        w_strb0_reg <= wstrb[0];
      end
    end
  end

  // Read path; data sampled when the address is taken
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
      rdata   <= dpc_pkg::DPC_RDATA_ZERO;
      rresp   <= dpc_pkg::DPC_RESP_OKAY;
    end else begin
      rvalid  <= rvalid_next;
      arready <= ~rvalid_next;
      if (ar_take) begin
        rdata <= rd_hit ? {24'h000000, regs.rd_data} : dpc_pkg::DPC_RDATA_ZERO;
        rresp <= rd_hit ? dpc_pkg::DPC_RESP_OKAY : dpc_pkg::DPC_RESP_SLVERR;
      end
    end
  end

  // Bus answers one cycle after the request completes
  a_bvalid_after_write: assert property (@(posedge sys_clk) disable iff (reset)
    do_write |=> bvalid)
    else $error("write response did not follow write");
endmodule : dpc_axil_slave

// file: dpc_fc_model.sv
// Purpose: Remote serializer model that drives forward-channel loads
// Assumes: Loads are one-cycle strobes in the sys_clk domain
// Notes:   Idle data shows the inverse of the last load, never stale data
`timescale 1ns/10ps
module dpc_fc_model (
  input  wire logic                     sys_clk,
  output logic                          fc_load_valid,
  output logic [dpc_pkg::DPC_FC_W-1:0]  fc_load_data,
  output logic                          remote_cp_capable
);
  // Idle link at time zero; remote supports protection by default
  initial begin
    fc_load_valid     = 1'b0;
    fc_load_data      = 7'h55;
    remote_cp_capable = 1'b1;
  end

  // One strobe per load; the line is scrambled after it so a stuck load shows up
  task automatic send(input logic [dpc_pkg::DPC_FC_W-1:0] d);
    @(posedge sys_clk);
    fc_load_valid <= 1'b1;
    fc_load_data  <= d;
    @(posedge sys_clk);
    fc_load_valid <= 1'b0;
    fc_load_data  <= ~d;
  endtask : send

  // Capability is a level owned by the remote side
  task automatic set_cap(input logic c);
    @(posedge sys_clk);
    remote_cp_capable <= c;
  endtask : set_cap
endmodule : dpc_fc_model

// file: datapath_control_register_tb.sv
// Purpose: Self-checking bench for the datapath control register
// Assumes: AXI4-Lite master in the bench, remote serializer in a model
// Notes:   Handshakes are sampled at the falling edge, driven after the rising one
`timescale 1ns/10ps
module datapath_control_register_tb;
  localparam logic [7:0] REG_ADDR = dpc_pkg::DPC_REG_INDEX << dpc_pkg::DPC_WORD_SHIFT;
  logic        sys_clk, reset, awvalid, wvalid, bready, arvalid, rready, vvf;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire logic [31:0] rdata;
  wire logic [1:0]  bresp, rresp;
  wire logic        awready, wready, bvalid, arready, rvalid, fcv, cap;
  wire logic [6:0]  fcd;
  wire logic        o_lk, o_ps, o_sn, o_rg, o_gt, o_cp, o_pa, o_4c, o_18, o_ib;
  wire logic [9:0]  outs = {o_lk, o_ps, o_sn, o_rg, o_gt, o_cp, o_pa, o_4c, o_18, o_ib};
  int fails = 0;
  int tests_run = 0;

  // Free-running clock, reset held for 8 cycles
  always #4 sys_clk = ~sys_clk;
  initial begin
    sys_clk = 1'b0; reset = 1'b1; vvf = 1'b0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'h0;
  end

  dpc_top dpc_top_i (.sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fc_load_valid(fcv), .fc_load_data(fcd), .remote_cp_capable(cap),
    .video_valid_flag(vvf), .lock_local_settings(o_lk), .frameless_pixel_pass(o_ps),
    .video_valid_sense(o_sn), .audio_relay_regen(o_rg), .pixel_gate(o_gt), .cp_disable(o_cp),
    .packet_audio_block(o_pa), .four_channel_en(o_4c), .color_18bit_mode(o_18), .inband_transport(o_ib));
  dpc_fc_model dpc_fc_model_i (.sys_clk(sys_clk), .fc_load_valid(fcv), .fc_load_data(fcd),
    .remote_cp_capable(cap));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Expected decoded outputs from register value, capability and framing input
  function automatic logic [9:0] exp_out(input logic [7:0] r, input logic c, input logic v);
    logic p;
    p = r[6] & c;
    return {r[7], p, r[5], r[4], p | (r[5] ? ~v : v), p, p | r[4], r[3] & r[0], r[2], r[1]};
  endfunction : exp_out

  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    @(posedge sys_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    while (!b_hs && n < 200) begin
      @(negedge sys_clk);
      aw_hs = awvalid && awready; w_hs = wvalid && wready; b_hs = bvalid && bready; r = bresp;
      @(posedge sys_clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
      n++;
    end
    if (b_hs !== 1'b1) chk(32'h0000_0DEA, 32'h0000_0000);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    r_hs = 1'b0;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!r_hs && n < 200) begin
      @(negedge sys_clk);
      ar_hs = arvalid && arready; r_hs = rvalid && rready; d = rdata; r = rresp;
      @(posedge sys_clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
      n++;
    end
    if (r_hs !== 1'b1) chk(32'h0000_0DEA, 32'h0000_0000);
  endtask : axi_rd

  task automatic wr_ok(input logic [7:0] d);
    logic [1:0] r;
    axi_wr(REG_ADDR, {24'h00_0000, d}, 4'hF, r);
    chk(r, dpc_pkg::DPC_RESP_OKAY);
  endtask : wr_ok

  // Read back the word and, once outputs have settled, the decoded controls
  task automatic rd_chk(input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(REG_ADDR, d, r);
    chk(d, {24'h00_0000, e});
    chk(r, dpc_pkg::DPC_RESP_OKAY);
    @(negedge sys_clk);
    chk(outs, exp_out(e, cap, vvf));
  endtask : rd_chk

  task automatic t_fields;
    logic [7:0] vals [5] = '{8'h5A, 8'h25, 8'hC9, 8'h16, 8'h00};
    foreach (vals[i]) begin
      wr_ok(vals[i]);
      rd_chk(vals[i]);
    end
  endtask : t_fields

  // Active-low framing sense at both flag levels, then pass-through ignoring framing
  task automatic t_gate;
    logic [7:0] cfg [2] = '{8'h20, 8'h40};
    foreach (cfg[i]) begin
      wr_ok(cfg[i]);
      for (int v = 0; v < 2; v++) begin
        @(posedge sys_clk);
        vvf <= v[0];
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(outs, exp_out(cfg[i], cap, vvf));
      end
    end
  endtask : t_gate

  task automatic t_fc;
    wr_ok(8'h00);
    dpc_fc_model_i.send(7'h5B);
    rd_chk(8'h5B);
    dpc_fc_model_i.send(7'h24);
    dpc_fc_model_i.send(7'h13);
    rd_chk(8'h13);
    wr_ok(8'h80);
    dpc_fc_model_i.send(7'h7F);
    rd_chk(8'h80);
    wr_ok(8'h00);
  endtask : t_fc

  task automatic t_cp;
    dpc_fc_model_i.set_cap(1'b0);
    wr_ok(8'h50);
    rd_chk(8'h50);
    dpc_fc_model_i.set_cap(1'b1);
    rd_chk(8'h50);
  endtask : t_cp

  // Unmapped word is refused; a write without the low lane has no effect
  task automatic t_bus_err;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(REG_ADDR + 8'h04, 32'h0000_00FF, 4'hF, r);
    chk(r, dpc_pkg::DPC_RESP_SLVERR);
    axi_rd(REG_ADDR + 8'h04, d, r);
    chk(d, dpc_pkg::DPC_RDATA_ZERO);
    chk(r, dpc_pkg::DPC_RESP_SLVERR);
    // Low address bits and upper data lanes must not matter
    axi_wr(REG_ADDR + 8'h03, 32'hA5C3_96FF, 4'hE, r);
    chk(r, dpc_pkg::DPC_RESP_OKAY);
    rd_chk(8'h50);
    axi_wr(REG_ADDR + 8'h01, 32'h5A3C_69C3, 4'h1, r);
    chk(r, dpc_pkg::DPC_RESP_OKAY);
    axi_rd(REG_ADDR + 8'h02, d, r);
    chk(d, 32'h0000_00C3);
    chk(r, dpc_pkg::DPC_RESP_OKAY);
  endtask : t_bus_err

  // Reset in mid-run clears a locked, non-zero word and every decoded control
  task automatic t_reset;
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk(outs, 10'h000);
    rd_chk(dpc_pkg::DPC_RESET_VALUE);
  endtask : t_reset

  task automatic summarize;
    $display("comparisons=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Main sequence: reset values first, then each scenario
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk(outs, 10'h000);
    rd_chk(dpc_pkg::DPC_RESET_VALUE);
    t_fields();
    t_gate();
    t_fc();
    t_cp();
    t_bus_err();
    t_reset();
    summarize();
  end

  // Watchdog well beyond the fewer than two hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule : datapath_control_register_tb
